/* inc/ppl_pkg.sv */
package ppl_pkg;
   // System clock 25 MHz
   localparam int SYS_CLK_HZ = 25000000;
   localparam int NS_PER_S = 1000000000;
   localparam int SYS_PERIOD_NS = NS_PER_S / SYS_CLK_HZ;
   // Times as printed
   localparam int REQ_LOW_MIN_US = 2;
   localparam int ACK_MAX_NS = 600;
   localparam int STATUS_LOW_MIN_US = 268;
   localparam int STATUS_LOW_MAX_US = 1506;
   localparam int STATUS_TO_CLK_MIN_US = 2;
   localparam int REQ_TO_CLK_MIN_US = 1506;
   localparam int INIT_MIN_US = 175;
   localparam int INIT_MAX_US = 437;
   localparam int USER_CLK_EN_PERIODS = 4;
   localparam int USER_INIT_PERIODS = 8576;
   localparam int CLK_MAX_X16_MHZ = 125;
   localparam int CLK_MAX_X32_MHZ = 100;
   localparam int NS_PER_US = 1000;
   // Cycle counts: least times round up
   localparam int REQ_LOW_CYC = (REQ_LOW_MIN_US * NS_PER_US + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int STATUS_LOW_CYC =
      (STATUS_LOW_MIN_US * NS_PER_US + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int ST2CK_CYC =
      (STATUS_TO_CLK_MIN_US * NS_PER_US + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CF2CK_CYC = (REQ_TO_CLK_MIN_US * NS_PER_US + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int INIT_MIN_CYC = (INIT_MIN_US * NS_PER_US + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   // Config clock divider: sys/4 = 6.25 MHz, below both maxima; the slower clock keeps
   // each word steady long enough for the device's toggle crossing to take it
   localparam int CCLK_HALF_CYC = 2;
   localparam int CNT_W = 20;
   localparam int DATA_W = 32;
   // Scheme select encodings
   typedef enum logic [1:0] {PPL_X8, PPL_X16, PPL_X32} ppl_scheme_t;
   localparam logic [3:0] RATIO_ONE = 4'h1;
   localparam logic [3:0] RATIO_TWO = 4'h2;
   localparam logic [3:0] RATIO_FOUR = 4'h4;
   localparam logic [3:0] RATIO_EIGHT = 4'h8;
   localparam logic [15:0] MASK_X8 = 16'h00ff;
   localparam logic [15:0] MASK_X16 = 16'hffff;

   function automatic logic [3:0] ppl_ratio(input ppl_scheme_t s, input logic dec,
                                            input logic sec);
      logic [3:0] r;
      r = RATIO_ONE;
      if (dec)
      begin
         case (s)
            PPL_X8: r = RATIO_TWO;
            PPL_X16: r = RATIO_FOUR;
            default: r = RATIO_EIGHT;
         endcase
      end
      else if (sec)
      begin
         case (s)
            PPL_X8: r = RATIO_ONE;
            PPL_X16: r = RATIO_TWO;
            default: r = RATIO_FOUR;
         endcase
      end
      return r;
   endfunction
endpackage

/* inc/ppl_link_if.sv */
`timescale 1ns/10ps
interface ppl_link_if;
   logic config_clock;
   logic [31:0] data;
   logic prog_req_n;
   logic status_n_dev_o;
   logic status_n_dev_oe;
   logic status_n_host_oe;
   logic status_n;
   logic load_done_dev_o;
   logic load_done_dev_oe;
   logic load_done;
   logic user_init_clock;
   // Open-drain status with pull-up: low if any party drives
   assign status_n = !((status_n_dev_oe && !status_n_dev_o) || status_n_host_oe);
   assign load_done = !(load_done_dev_oe && !load_done_dev_o);

   modport device (
      input config_clock, data, prog_req_n, status_n, user_init_clock,
      output status_n_dev_o, status_n_dev_oe, load_done_dev_o, load_done_dev_oe
   );
   modport host (
      output config_clock, data, prog_req_n, status_n_host_oe, user_init_clock,
      input status_n, load_done
   );
endinterface

/* rtl/ppl_device.sv */
`timescale 1ns/10ps
// Rules for this block and its host
// - No options: one clock per word
// - Decompression: ratio 2, 4, 8 by width
// - Security only: ratio 1, 2, 4 by width
// - Host clocks r times word rate
// - Host clocks r-1 more after last word
// - Narrow schemes use low data lines only
// - Host holds request low at least 2us
// - Load-done low within 600 ns of request
// - Status low within 600 ns of request
// - Status low 268 to 1506 us
// - Status high by 1506 us after release
// - Host waits 2us after status rises
// - Blind host waits 1506us after request
// - Clock at most 125 or 100 MHz
// - Oscillator init: user mode 175-437 us
// - User clock init: 8576 periods after enable
// - Request low in user mode reconfigures
// - Load-done rises only after full image
// - Two falling edges after load-done
// - Clock pauses only low; data first (host sets data on the same sys edge that raises the clock)
module ppl_device #(
   parameter int IMAGE_WORDS = 16,
   parameter int STATUS_LOW_CYC = ppl_pkg::STATUS_LOW_CYC,
   parameter int INIT_CYC = ppl_pkg::INIT_MIN_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   ppl_link_if.device link,
   input wire logic [1:0] scheme_select_i,
   input wire logic decompress_en_i,
   input wire logic security_en_i,
   input wire logic user_clk_init_en_i,
   output logic word_valid_o,
   output logic [31:0] word_data_o,
   output logic user_mode_o
);
   typedef enum logic [2:0] {ST_RESET, ST_STATUS, ST_LOAD, ST_DONE, ST_INIT, ST_USER} ppl_dst_t;
   ppl_dst_t state_r, state_nxt;
   logic [ppl_pkg::CNT_W-1:0] cnt_r;
   logic req_s1_r, req_s2_r, stat_s1_r, stat_s2_r;
   logic [15:0] ucnt_r;
   // Link-clock side
   // Link-side state has no reset; its clock only runs once loading has begun,
   // so these start values stand in for one
   logic [3:0] slot_r = 4'h0;
   logic [3:0] slot_nxt;
   logic [31:0] word_r;
   logic wtog_r = 1'b0;
   logic full_lk_r = 1'b0;
   logic take_word;
   logic [ppl_pkg::CNT_W-1:0] wcnt_r = '0;
   logic [ppl_pkg::CNT_W-1:0] wcnt_nxt;
   logic [31:0] lane_en;
   logic [1:0] fall_cnt_r;
   // Sys-side crossings from link clock
   logic wtog_s1_r, wtog_s2_r, wtog_s3_r, full_s1_r, full_s2_r, fall_s1_r, fall_s2_r;
   logic full_r;
   logic [3:0] ratio;
   logic [31:0] data_masked;
   logic req_low, word_evt, loading;

   assign ratio = ppl_pkg::ppl_ratio(ppl_pkg::ppl_scheme_t'(scheme_select_i),
                                     decompress_en_i, security_en_i);
   // Unused upper lanes read as zero whatever the host leaves on them
   assign lane_en = (scheme_select_i == ppl_pkg::PPL_X8) ? {16'h0000, ppl_pkg::MASK_X8} :
                    (scheme_select_i == ppl_pkg::PPL_X16) ? {16'h0000, ppl_pkg::MASK_X16} :
                    32'hffff_ffff;
   for (genvar b = 0; b < ppl_pkg::DATA_W; b++)
   begin : g_lane
      assign data_masked[b] = link.data[b] & lane_en[b];
   end
   assign req_low = !req_s2_r;
   assign loading = (state_r == ST_LOAD);
   assign word_evt = wtog_s2_r ^ wtog_s3_r;
   assign slot_nxt = (slot_r + 4'h1 >= ratio) ? 4'h0 : slot_r + 4'h1;
   assign take_word = (slot_r == 4'h0) && (wcnt_r < ppl_pkg::CNT_W'(IMAGE_WORDS));
   assign wcnt_nxt = take_word ? wcnt_r + 1'b1 : wcnt_r;

   // Status is open drain; we drive low only, never high
   assign link.status_n_dev_o = 1'b0;
   assign link.status_n_dev_oe = (state_r == ST_RESET) || (state_r == ST_STATUS);
   assign link.load_done_dev_o = 1'b0;
   assign link.load_done_dev_oe = (state_r != ST_DONE) && (state_r != ST_INIT) &&
                                  (state_r != ST_USER);

   // Link clock domain: word capture. The clock is still while the load state is
   // entered, and the host's wait (after status rises, or the blind wait after request release) keeps loading settled long
   // before the first edge, so it is read directly; a synchroniser here would eat
   // the first words, since this clock does not run until data flows.
   always_ff @(posedge link.config_clock)
   begin
      if (!loading)
      begin
         slot_r <= 4'h0;
         wcnt_r <= '0;
         full_lk_r <= 1'b0;
      end
      else
      begin
         slot_r <= slot_nxt;
         wcnt_r <= wcnt_nxt;
         // Image complete once the last slot has run out; this bit crosses in place of the word count
         full_lk_r <= (wcnt_nxt == ppl_pkg::CNT_W'(IMAGE_WORDS)) && (slot_nxt == 4'h0);
         if (take_word)
         begin
            word_r <= data_masked;
            wtog_r <= ~wtog_r;
         end
      end
   end

   // Falling edges after load-done; stopped clock cannot glitch this
   always_ff @(negedge link.config_clock)
   begin
      if (!full_r || state_r != ST_DONE)
         fall_cnt_r <= 2'h0;
      else if (fall_cnt_r != 2'h2)
         fall_cnt_r <= fall_cnt_r + 2'h1;
   end

   // Sys domain
   always_ff @(posedge sys_clk_i)
   begin
      req_s1_r <= link.prog_req_n;
      req_s2_r <= req_s1_r;
      stat_s1_r <= link.status_n;
      stat_s2_r <= stat_s1_r;
      wtog_s1_r <= wtog_r;
      wtog_s2_r <= wtog_s1_r;
      wtog_s3_r <= wtog_s2_r;
      full_s1_r <= full_lk_r;
      full_s2_r <= full_s1_r;
      fall_s1_r <= (fall_cnt_r == 2'h2);
      fall_s2_r <= fall_s1_r;
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: if (!req_low) state_nxt = ST_STATUS;
         ST_STATUS: if (cnt_r >= ppl_pkg::CNT_W'(STATUS_LOW_CYC)) state_nxt = ST_LOAD;
         ST_LOAD: if (full_s2_r) state_nxt = ST_DONE;
         ST_DONE: if (fall_s2_r) state_nxt = ST_INIT;
         ST_INIT: if (user_clk_init_en_i ? (ucnt_r == ppl_pkg::USER_INIT_PERIODS[15:0]) :
                      (cnt_r >= ppl_pkg::CNT_W'(INIT_CYC))) state_nxt = ST_USER;
         ST_USER: state_nxt = ST_USER;
         default: state_nxt = ST_RESET;
      endcase
      if (req_low)
         state_nxt = ST_RESET;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_r <= ST_RESET;
         cnt_r <= '0;
         full_r <= 1'b0;
         word_valid_o <= 1'b0;
         word_data_o <= 32'h0000_0000;
         user_mode_o <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         // Status counter clears on every state change and otherwise counts, whoever holds status low
         cnt_r <= (state_nxt != state_r || (state_r == ST_STATUS && !stat_s2_r &&
                   cnt_r >= ppl_pkg::CNT_W'(STATUS_LOW_CYC))) ? '0 : cnt_r + 1'b1;
         full_r <= (state_r == ST_DONE);
         word_valid_o <= word_evt && loading;
         if (word_evt)
            word_data_o <= word_r;
         user_mode_o <= (state_nxt == ST_USER);
      end
   end

   // User init clock periods counted in its own domain
   logic uclr_s1_r, uclr_s2_r;
   always_ff @(posedge link.user_init_clock)
   begin
      uclr_s1_r <= (state_r != ST_INIT);
      uclr_s2_r <= uclr_s1_r;
      if (uclr_s2_r)
         ucnt_r <= 16'h0000;
      else if (ucnt_r != ppl_pkg::USER_INIT_PERIODS[15:0])
         ucnt_r <= ucnt_r + 16'h0001;
   end
endmodule

/* rtl/ppl_host.sv */
`timescale 1ns/10ps
module ppl_host #(
   parameter int REQ_TO_CLK_CYC = ppl_pkg::CF2CK_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   ppl_link_if.host link,
   input wire logic start_i,
   input wire logic [3:0] ratio_i,
   input wire logic monitor_status_i,
   input wire logic [31:0] word_i,
   input wire logic word_last_i,
   input wire logic word_valid_i,
   output logic word_ready_o,
   output logic busy_o,
   output logic done_o
);
   typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT, H_SEND, H_TAIL, H_FALL} ppl_hst_t;
   ppl_hst_t st_r;
   logic [ppl_pkg::CNT_W-1:0] cnt_r;
   logic [3:0] slot_r;
   logic ck_r, last_r, st1_r, st2_r, ld1_r, ld2_r;
   logic [31:0] data_r;
   logic [1:0] ph_r;
   logic tick;
   // Clock phase changes only on a divider tick
   assign tick = (ph_r == 2'(ppl_pkg::CCLK_HALF_CYC - 1));

   assign link.config_clock = ck_r;
   assign link.data = data_r;
   assign link.prog_req_n = (st_r != H_REQ);
   assign link.status_n_host_oe = 1'b0;
   assign link.user_init_clock = sys_clk_i;
   // Take next word when clock low and slot complete
   assign word_ready_o = (st_r == H_SEND) && !ck_r && slot_r == 4'h0 && !last_r && tick;
   assign busy_o = (st_r != H_IDLE);

   always_ff @(posedge sys_clk_i)
   begin
      st1_r <= link.status_n;
      st2_r <= st1_r;
      ld1_r <= link.load_done;
      ld2_r <= ld1_r;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         st_r <= H_IDLE;
         cnt_r <= '0;
         slot_r <= 4'h0;
         ck_r <= 1'b0;
         last_r <= 1'b0;
         data_r <= 32'h0000_0000;
         done_o <= 1'b0;
         ph_r <= 2'h0;
      end
      else
      begin
         cnt_r <= cnt_r + 1'b1;
         ph_r <= tick ? 2'h0 : ph_r + 2'h1;
         case (st_r)
            H_IDLE:
               if (start_i)
               begin
                  st_r <= H_REQ;
                  cnt_r <= '0;
                  done_o <= 1'b0;
               end
            H_REQ:
               if (cnt_r >= ppl_pkg::CNT_W'(ppl_pkg::REQ_LOW_CYC))
               begin
                  st_r <= H_WAIT;
                  cnt_r <= '0;
               end
            H_WAIT:
               if (monitor_status_i ? !st2_r : 1'b0)
                  cnt_r <= '0;
               else if (monitor_status_i ? cnt_r >= ppl_pkg::CNT_W'(ppl_pkg::ST2CK_CYC) :
                        cnt_r >= ppl_pkg::CNT_W'(REQ_TO_CLK_CYC))
                  st_r <= H_SEND;
            H_SEND:
               if (tick && ck_r)
               begin
                  ck_r <= 1'b0;
                  if (last_r && slot_r == 4'h0)
                  begin
                     st_r <= H_FALL;
                     slot_r <= 4'h0;
                  end
               end
               else if (tick && slot_r != 4'h0)
               begin
                  ck_r <= 1'b1;
                  slot_r <= (slot_r + 4'h1 >= ratio_i) ? 4'h0 : slot_r + 4'h1;
               end
               else if (tick && word_valid_i)
               begin
                  data_r <= word_i;
                  last_r <= word_last_i;
                  ck_r <= 1'b1;
                  slot_r <= (ratio_i > 4'h1) ? 4'h1 : 4'h0;
               end
            H_FALL:
               if (ld2_r && tick)
               begin
                  ck_r <= ~ck_r;
                  if (ck_r)
                     slot_r <= slot_r + 4'h1;
                  if (ck_r && slot_r == 4'h1)
                  begin
                     st_r <= H_IDLE;
                     last_r <= 1'b0;
                     slot_r <= 4'h0;
                     done_o <= 1'b1;
                  end
               end
            default: st_r <= H_IDLE;
         endcase
      end
   end
endmodule

/* tb/ppl_link_asserts.sv */
`timescale 1ns/10ps
module ppl_link_asserts #(
   parameter int IMAGE_WORDS = 16,
   parameter int STATUS_LOW_CYC = 20
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic config_clock,
   input wire logic prog_req_n,
   input wire logic status_n,
   input wire logic load_done
);
   localparam int REL_MAX_CYC = 37650;
   int req_low_cnt;
   int st_low_cnt;
   int st_hi_cnt;
   int rel_cnt;
   int rise_cnt;
   logic seen_cfg_r;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   // Reset-time lows are not a configuration, so the status-width, image and falling-edge checks wait for a request
   always_ff @(posedge sys_clk_i)
   begin
      req_low_cnt <= (reset_i || prog_req_n) ? 0 : req_low_cnt + 1;
      st_low_cnt <= (reset_i || status_n) ? 0 : st_low_cnt + 1;
      st_hi_cnt <= (reset_i || !status_n) ? 0 : st_hi_cnt + 1;
      rel_cnt <= (reset_i || !prog_req_n || status_n) ? 0 : rel_cnt + 1;
      rise_cnt <= (reset_i || !prog_req_n) ? 0 : rise_cnt + int'($rose(config_clock));
      seen_cfg_r <= !reset_i && (seen_cfg_r || !prog_req_n);
   end
   AST_LOAD_LOW: assert property ($fell(prog_req_n) |-> ##[0:15] !load_done)
      else $error("load done not low in time");
   AST_STATUS_LOW: assert property ($fell(prog_req_n) |-> ##[0:15] !status_n)
      else $error("status not low in time");
   AST_STATUS_MIN: assert property ($rose(status_n) && seen_cfg_r |-> st_low_cnt >= STATUS_LOW_CYC)
      else $error("status low too short");
   AST_STATUS_REL: assert property (rel_cnt <= REL_MAX_CYC)
      else $error("status not released");
   AST_REQ_WIDTH: assert property ($rose(prog_req_n) |-> req_low_cnt >= ppl_pkg::REQ_LOW_CYC)
      else $error("request pulse too short");
   AST_CLK_AFTER_ST: assert property ($rose(config_clock) |-> st_hi_cnt >= ppl_pkg::ST2CK_CYC)
      else $error("clock too soon after status");
   AST_LOAD_IMAGE: assert property ($rose(load_done) && seen_cfg_r |-> rise_cnt >= IMAGE_WORDS)
      else $error("load done before full image");
   AST_CLK_HIGH: assert property ($rose(config_clock) |=> config_clock ##1 !config_clock)
      else $error("clock held high");
   AST_TWO_FALLS: assert property ($rose(load_done) && seen_cfg_r |->
      ##[0:20] $fell(config_clock) ##[1:20] $fell(config_clock))
      else $error("missing falling edges after load done");
   COV_LOADED: cover property ($rose(load_done) && seen_cfg_r);
   COV_STATUS: cover property ($rose(status_n) && seen_cfg_r);
   COV_RECONF: cover property ($fell(prog_req_n) && load_done);
endmodule

/* tb/fpp_config_slave_port_tb.sv */
`timescale 1ns/10ps
module fpp_config_slave_port_tb;
   localparam int IW = 5;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [1:0] scheme_select_i = 2'h0;
   logic decompress_en_i = 1'b0;
   logic security_en_i = 1'b0;
   logic user_clk_init_en_i = 1'b0;
   logic start_i = 1'b0;
   logic [3:0] ratio_i = 4'h1;
   logic monitor_status_i = 1'b0;
   logic [31:0] word_i = 32'h0;
   logic word_last_i = 1'b0;
   logic word_valid_i = 1'b0;
   logic word_valid_o;
   logic word_ready_o;
   logic busy_o;
   logic done_o;
   logic user_mode_o;
   logic [31:0] word_data_o;
   int failures = 0;
   int compares = 0;
   int seen = 0;
   logic [31:0] exp_q[$];
   ppl_link_if lk();
   always #20 sys_clk_i = ~sys_clk_i;
   ppl_device #(.IMAGE_WORDS(IW), .STATUS_LOW_CYC(20), .INIT_CYC(20)) ppl_device_i (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(lk.device),
      .scheme_select_i(scheme_select_i), .decompress_en_i(decompress_en_i),
      .security_en_i(security_en_i), .user_clk_init_en_i(user_clk_init_en_i),
      .word_valid_o(word_valid_o), .word_data_o(word_data_o), .user_mode_o(user_mode_o));
   // Blind wait kept longer than the shortened status pulse
   ppl_host #(.REQ_TO_CLK_CYC(100)) ppl_host_i (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(lk.host), .start_i(start_i),
      .ratio_i(ratio_i), .monitor_status_i(monitor_status_i), .word_i(word_i),
      .word_last_i(word_last_i), .word_valid_i(word_valid_i), .word_ready_o(word_ready_o),
      .busy_o(busy_o), .done_o(done_o));
   ppl_link_asserts #(.IMAGE_WORDS(IW), .STATUS_LOW_CYC(20)) ppl_link_asserts_i (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .config_clock(lk.config_clock),
      .prog_req_n(lk.prog_req_n), .status_n(lk.status_n), .load_done(lk.load_done));

   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("counts compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function automatic logic [3:0] exp_ratio(input int s, input bit d, input bit c);
      return d ? 4'h2 << s : (c ? 4'h1 << s : 4'h1);
   endfunction

   function automatic logic [31:0] mask(input int s);
      return s == 0 ? 32'hff : (s == 1 ? 32'hffff : 32'hffffffff);
   endfunction

   always @(posedge sys_clk_i)
      if (word_valid_o === 1'b1)
      begin
         seen++;
         cmp("word", exp_q.size() ? exp_q.pop_front() : 32'hx, word_data_o);
      end

   task automatic run(input int s, input bit d, input bit c, input bit uc);
      int n;
      logic [31:0] w;
      @(posedge sys_clk_i);
      scheme_select_i <= s[1:0];
      decompress_en_i <= d;
      security_en_i <= c;
      user_clk_init_en_i <= uc;
      ratio_i <= exp_ratio(s, d, c);
      monitor_status_i <= 1'($urandom);
      start_i <= 1'b1;
      seen = 0;
      @(posedge sys_clk_i);
      start_i <= 1'b0;
      for (int i = 0; i < IW; i++)
      begin
         w = $urandom;
         word_i <= w;
         word_last_i <= (i == IW - 1);
         word_valid_i <= 1'b1;
         do @(posedge sys_clk_i); while (word_ready_o !== 1'b1);
         exp_q.push_back(w & mask(s));
      end
      word_valid_i <= 1'b0;
      while (lk.load_done !== 1'b1) @(posedge sys_clk_i);
      n = 0;
      while (user_mode_o !== 1'b1)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      cmp("init_wait", 32'h1, 32'(n >= (uc ? 8584 : 20)));
      repeat (10) @(posedge sys_clk_i);
      cmp("words", IW, seen);
      cmp("host_done", 32'h1, {31'h0, done_o === 1'b1 && busy_o === 1'b0});
      $display("test done scheme %0d dec %0b sec %0b", s, d, c);
   endtask

   initial
   begin
      void'($urandom(32'h6c84));
      repeat (6) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      // Each pass after the first reconfigures from user mode
      for (int t = 0; t < 12; t++)
         run(t / 4, t[1], t[0], t == 5);
      finish_test();
   end

   initial
   begin
      #(40 * 40000);
      failures++;
      finish_test();
   end
endmodule
